// >>> logic/bopx_alu.sv
// combinational byte alu for the execute block
// assumes operands are stable within the cycle
module bopx_alu
    import bopx_pkg::*;
(
    // operation and operands
    input wire bopx_op_e op,
    input wire logic [BOPX_DATA_W-1:0] fval,
    input wire logic [BOPX_DATA_W-1:0] wval,
    input wire logic [BOPX_DATA_W-1:0] lit,
    // result
    output logic [BOPX_DATA_W-1:0] result,
    output logic is_zero
);
    // result selection per operation
    always_comb begin
        case (op)
            BOPX_OP_DEC_FILE, BOPX_OP_DSKZ: result = fval - BOPX_ONE; // [RQ1] [RQ3]
            BOPX_OP_ISKZ: result = fval + BOPX_ONE;               // [RQ5]
            BOPX_OP_ORLW: result = wval | lit;                    // [RQ9]
            default: result = BOPX_ZERO;                          // [RQ2]
        endcase
        is_zero = (result == BOPX_ZERO);                          // [RQ10]
    end
endmodule // bopx_alu

// >>> logic/bopx_exec.sv
// execute stage for six byte and branch operations
// assumes a decoder feeds INSTR and file read data arrives same cycle
// How it works
// RQ1: decrement file, destination bit picks target, Z updated
// RQ2: clear work reg to zero, set Z
// RQ3: decrement-skip stores result, flags unchanged
// RQ4: decrement-skip zero result squashes next instruction
// RQ5: increment-skip stores result, flags unchanged
// RQ6: increment-skip zero result squashes next instruction
// RQ7: branch loads literal, upper pc from latch
// RQ8: branch takes two cycles, flags unchanged
// RQ9: OR literal into work reg, Z updated
// RQ10: Z set on zero result, else cleared
// RQ11: upper pc bits come from latch 6..3
module bopx_exec
    import bopx_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // instruction stream
    input wire bopx_instr_s INSTR,
    input wire logic INSTR_VALID,
    input wire logic [BOPX_LATCH_W-1:0] PAGE_LATCH,
    // file register read data for INSTR.faddr
    input wire logic [BOPX_DATA_W-1:0] FILE_RDATA,
    // file register write port
    output bopx_fwr_s FILE_WR,
    // architectural state
    output logic [BOPX_DATA_W-1:0] WORK_REG,
    output logic ZERO_FLAG,
    output logic [BOPX_PC_W-1:0] PROG_COUNTER,
    // one while the current slot is a forced no-operation
    output logic SQUASH
);
    // slot kind: normal execution or a flushed slot that only advances the counter
    typedef enum logic {
        BOPX_RUN = 1'b0, // instruction in this slot executes
        BOPX_FLUSH = 1'b1 // instruction in this slot is discarded
    } bopx_st_e;

    bopx_st_e state; // current slot kind
    bopx_st_e next_state; // slot kind for the next edge
    bopx_fwr_s next_file_wr; // file write request for the next edge
    logic [BOPX_DATA_W-1:0] next_work_reg; // working register next value
    logic next_zero_flag; // zero flag next value
    logic [BOPX_PC_W-1:0] next_prog_counter; // counter next value
    logic next_squash; // squash output next value
    logic [BOPX_DATA_W-1:0] alu_result; // alu output
    logic alu_zero; // alu zero detect
    logic live; // instruction really executes

    // skip-type operations share the squash-on-zero behaviour
    function automatic logic is_skip_op(input bopx_op_e op);
        return (op == BOPX_OP_DSKZ) || (op == BOPX_OP_ISKZ);
    endfunction

    // shared arithmetic
    bopx_alu u_alu (
        .op(INSTR.op),
        .fval(FILE_RDATA),
        .wval(WORK_REG),
        .lit(INSTR.lit[BOPX_DATA_W-1:0]),
        .result(alu_result),
        .is_zero(alu_zero)
    );

    // a squashed slot ignores whatever the decoder presents
    assign live = INSTR_VALID && (state == BOPX_RUN);

    // next architectural state; defaults keep everything and step the counter
    always_comb begin
        next_state = BOPX_RUN;
        next_work_reg = WORK_REG;
        next_zero_flag = ZERO_FLAG;
        next_prog_counter = PROG_COUNTER + BOPX_PC_STEP;
        next_file_wr = '0;
        if (!INSTR_VALID && state == BOPX_RUN) begin
            // stall: hold pc, the decoder has nothing to hand over
            next_prog_counter = PROG_COUNTER;
        end else if (live) begin
            case (INSTR.op)
                BOPX_OP_DEC_FILE, BOPX_OP_DSKZ, BOPX_OP_ISKZ: begin
                    // destination bit picks work reg or file reg
                    if (INSTR.dest == DEST_WORK) begin
                        // result to work reg, file reg untouched
                        next_work_reg = alu_result; // [RQ1] [RQ3] [RQ5]
                    end else begin
                        // result back to the file reg one cycle later
                        next_file_wr.we = 1'b1; // [RQ1] [RQ3] [RQ5]
                        next_file_wr.addr = INSTR.faddr;
                        next_file_wr.data = alu_result;
                    end
                    if (INSTR.op == BOPX_OP_DEC_FILE) begin
                        // plain decrement is the only one of the three that touches Z
                        next_zero_flag = alu_zero; // [RQ1] [RQ10]
                    end else if (alu_zero) begin
                        // skip ops leave Z alone and flush the next slot instead
                        next_state = BOPX_FLUSH; // [RQ4] [RQ6]
                    end
                end
                BOPX_OP_CLR_WORK: begin
                    // no operands; file read data is ignored
                    next_work_reg = BOPX_ZERO; // [RQ2]
                    next_zero_flag = 1'b1; // [RQ2]
                end
                BOPX_OP_ORLW: begin
                    // only the low byte of the literal field takes part
                    next_work_reg = alu_result; // [RQ9]
                    next_zero_flag = alu_zero; // [RQ9] [RQ10]
                end
                BOPX_OP_BRAN: begin
                    // literal low, latch 6..3 high; second cycle is a flush
                    next_prog_counter = {PAGE_LATCH[BOPX_LATCH_HI:BOPX_LATCH_LO],
                                         INSTR.lit}; // [RQ7] [RQ11]
                    next_state = BOPX_FLUSH; // [RQ8]
                end
                default: begin
                    // no-operation: only pc advances
                end
            endcase
        end
        // the squash output mirrors the slot kind so it can leave a flop directly
        next_squash = (next_state == BOPX_FLUSH);
    end

    // register stage: synchronous reset, otherwise take the next values
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            // reset leaves a clean running slot and no pending write
            state <= BOPX_RUN;
            WORK_REG <= BOPX_ZERO;
            ZERO_FLAG <= 1'b0;
            PROG_COUNTER <= BOPX_PC_RST;
            FILE_WR <= '0;
            SQUASH <= 1'b0;
        end else begin
            state <= next_state;
            WORK_REG <= next_work_reg;
            ZERO_FLAG <= next_zero_flag;
            PROG_COUNTER <= next_prog_counter;
            FILE_WR <= next_file_wr;
            SQUASH <= next_squash;
        end
    end

    // a live skip-type op with zero result
    sequence s_skip_zero;
        live && is_skip_op(INSTR.op) && alu_zero;
    endsequence
    // a live skip-type op with nonzero result
    sequence s_skip_nonzero;
        live && is_skip_op(INSTR.op) && !alu_zero;
    endsequence
    // a live branch
    sequence s_branch;
        live && INSTR.op == BOPX_OP_BRAN;
    endsequence
    // exactly one flushed slot, then a running one again
    sequence s_one_flush;
        (SQUASH && state == BOPX_FLUSH) ##1 (!SQUASH && state == BOPX_RUN);
    endsequence

    // skip ops: zero result flushes exactly one slot, nonzero runs on
    a_skip_squash_next: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ4] [RQ6]
        s_skip_zero |=> s_one_flush)
        else $error("zero skip did not squash next slot");
    a_skip_nonzero_runs: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ4] [RQ6]
        s_skip_nonzero |=> !SQUASH)
        else $error("nonzero skip squashed next slot");
    a_skip_flags_keep: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ3] [RQ5]
        (live && is_skip_op(INSTR.op)) |=> ZERO_FLAG == $past(ZERO_FLAG))
        else $error("skip op changed zero flag");
    // skip ops store the stepped file value in the work reg when told to
    a_skip_work_value: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ3] [RQ5]
        (live && is_skip_op(INSTR.op) && INSTR.dest == DEST_WORK) |=>
        WORK_REG == (($past(INSTR.op) == BOPX_OP_ISKZ) ? $past(FILE_RDATA) + BOPX_ONE
                     : $past(FILE_RDATA) - BOPX_ONE) && !FILE_WR.we)
        else $error("skip op stored wrong work value");

    // a flushed slot discards its instruction and only steps the counter
    a_flush_discard: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ4] [RQ6]
        (state == BOPX_FLUSH) |=> $stable(WORK_REG) && $stable(ZERO_FLAG) && !FILE_WR.we
        && PROG_COUNTER == $past(PROG_COUNTER) + BOPX_PC_STEP)
        else $error("flushed slot changed state");

    // branch: target from latch and literal, then one flushed slot, flags kept
    a_branch_target: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ7] [RQ11]
        s_branch |=> PROG_COUNTER == {$past(PAGE_LATCH[BOPX_LATCH_HI:BOPX_LATCH_LO]),
                                      $past(INSTR.lit)})
        else $error("branch target wrong");
    a_branch_two_cyc: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ8]
        s_branch |=> s_one_flush)
        else $error("branch not two cycles");
    a_branch_flags: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ8]
        s_branch |=> $stable(ZERO_FLAG) && $stable(WORK_REG) && !FILE_WR.we)
        else $error("branch changed state");

    // clear: work reg zero and Z set
    a_clear_work: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ2]
        (live && INSTR.op == BOPX_OP_CLR_WORK) |=> WORK_REG == BOPX_ZERO && ZERO_FLAG)
        else $error("clear work reg failed");

    // or literal: low byte of the literal only, Z follows the result
    a_or_literal: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ9] [RQ10]
        (live && INSTR.op == BOPX_OP_ORLW) |=>
        WORK_REG == ($past(WORK_REG) | $past(INSTR.lit[BOPX_DATA_W-1:0]))
        && ZERO_FLAG == (WORK_REG == BOPX_ZERO))
        else $error("or literal result wrong");

    // plain decrement, both destinations, Z follows the result
    a_dec_file_dest: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ1] [RQ10]
        (live && INSTR.op == BOPX_OP_DEC_FILE && INSTR.dest != DEST_WORK) |=>
        FILE_WR.we && FILE_WR.addr == $past(INSTR.faddr)
        && FILE_WR.data == $past(FILE_RDATA) - BOPX_ONE
        && ZERO_FLAG == (FILE_WR.data == BOPX_ZERO))
        else $error("decrement to file wrong");
    a_dec_file_work: assert property (@(posedge CLK) disable iff (!RST_N) // [RQ1] [RQ10]
        (live && INSTR.op == BOPX_OP_DEC_FILE && INSTR.dest == DEST_WORK) |=>
        !FILE_WR.we && WORK_REG == $past(FILE_RDATA) - BOPX_ONE
        && ZERO_FLAG == (WORK_REG == BOPX_ZERO))
        else $error("decrement to work reg wrong");
endmodule // bopx_exec

// >>> logic/bopx_pkg.sv
// package for the byte-op and branch execute block
// assumes one clock domain, synchronous active-low reset
package bopx_pkg;
    localparam int BOPX_DATA_W = 8; // file and working register width
    localparam int BOPX_ADDR_W = 7; // file register address width
    localparam int BOPX_PC_W = 15; // program counter width
    localparam int BOPX_LIT_W = 11; // branch literal width
    localparam int BOPX_LATCH_W = 7; // page latch width
    localparam int BOPX_LATCH_LO = 3; // lowest page latch bit used by branch
    localparam int BOPX_LATCH_HI = 6; // highest page latch bit used by branch
    localparam logic [BOPX_DATA_W-1:0] BOPX_ONE = 8'h01; // step of inc/dec
    localparam logic [BOPX_DATA_W-1:0] BOPX_ZERO = 8'h00; // cleared value
    localparam logic [BOPX_PC_W-1:0] BOPX_PC_STEP = 15'h0001; // sequential fetch
    localparam logic [BOPX_PC_W-1:0] BOPX_PC_RST = 15'h0000; // pc after reset
    localparam logic DEST_WORK = 1'b0; // destination bit value selecting work reg

    // operation codes presented to the block
    typedef enum logic [2:0] {
        BOPX_OP_NONE = 3'b000,
        BOPX_OP_DEC_FILE = 3'b001,
        BOPX_OP_CLR_WORK = 3'b010,
        BOPX_OP_DSKZ = 3'b011,
        BOPX_OP_ISKZ = 3'b100,
        BOPX_OP_BRAN = 3'b101,
        BOPX_OP_ORLW = 3'b110
    } bopx_op_e;

    // one decoded instruction
    typedef struct packed {
        bopx_op_e op;
        logic dest;
        logic [BOPX_ADDR_W-1:0] faddr;
        logic [BOPX_LIT_W-1:0] lit;
    } bopx_instr_s;

    // file register write request
    typedef struct packed {
        logic we;
        logic [BOPX_ADDR_W-1:0] addr;
        logic [BOPX_DATA_W-1:0] data;
    } bopx_fwr_s;
endpackage

// >>> verification/test_byte_op_and_branch_execute.sv
// self-checking testbench for the byte-op and branch execute block
// assumes bopx_pkg and bopx_exec are compiled first; file reads come from the bench
module test_byte_op_and_branch_execute
    import bopx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // stimulus toward the design
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    bopx_instr_s INSTR = '0;
    logic INSTR_VALID = 1'b0;
    logic [BOPX_LATCH_W-1:0] PAGE_LATCH = '0;
    logic [BOPX_DATA_W-1:0] FILE_RDATA = '0;
    // design outputs
    bopx_fwr_s FILE_WR;
    logic [BOPX_DATA_W-1:0] WORK_REG;
    logic ZERO_FLAG;
    logic [BOPX_PC_W-1:0] PROG_COUNTER;
    logic SQUASH;
    int err_count = 0;
    int samples_checked = 0;
    // reference state, kept as plain integers
    int m_w, m_z, m_pc, m_sq, m_we, m_addr, m_data;

    // 50 MHz clock
    always #10 CLK = ~CLK;

    bopx_exec dut (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
        .PAGE_LATCH(PAGE_LATCH), .FILE_RDATA(FILE_RDATA), .FILE_WR(FILE_WR),
        .WORK_REG(WORK_REG), .ZERO_FLAG(ZERO_FLAG), .PROG_COUNTER(PROG_COUNTER),
        .SQUASH(SQUASH));

    // verdict, reached from the main sequence or the watchdog
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // compare all visible state with the reference
    task chk;
        samples_checked++;
        if ({WORK_REG, ZERO_FLAG, PROG_COUNTER, SQUASH, FILE_WR.we} !== {m_w[7:0], m_z[0],
            m_pc[14:0], m_sq[0], m_we[0]}) begin
            err_count++;
            $display("BAD %0t state w=%h z=%b pc=%h sq=%b", $time, WORK_REG, ZERO_FLAG,
                PROG_COUNTER, SQUASH);
        end
        if (m_we && {FILE_WR.addr, FILE_WR.data} !== {m_addr[6:0], m_data[7:0]}) begin
            err_count++;
            $display("BAD %0t file write %h %h", $time, FILE_WR.addr, FILE_WR.data);
        end
    endtask

    // hold reset two edges, then expect cleared state
    task rst;
        RST_N = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        {m_w, m_z, m_pc, m_sq, m_we} = '0;
        chk();
        RST_N = 1'b1;
    endtask

    // drive one slot, step the reference one edge, compare
    task slot(input int op, input int dest, input int fa, input int lit, input int fd,
        input int vld);
        int r;
        INSTR.op = bopx_op_e'(op[2:0]);
        INSTR.dest = dest[0];
        INSTR.faddr = fa[6:0];
        INSTR.lit = lit[10:0];
        FILE_RDATA = fd[7:0];
        INSTR_VALID = vld[0];
        @(posedge CLK);
        #1;
        m_we = 0;
        if (m_sq) begin
            // discarded slot still advances the counter
            m_pc++;
            m_sq = 0;
        end else if (vld) begin
            m_pc++;
            case (op)
                1, 3, 4: begin
                    r = (op == 4 ? fd + 1 : fd - 1) & 32'hFF;
                    if (dest == 0) m_w = r;
                    else {m_we, m_addr, m_data} = {32'h1, fa, r};
                    if (op == 1) m_z = (r == 0);
                    else m_sq = (r == 0);
                end
                2: {m_w, m_z} = {32'h0, 32'h1};
                5: {m_pc, m_sq} = {(int'(PAGE_LATCH[6:3]) << 11) | (lit & 32'h7FF), 32'h1};
                6: begin
                    m_w = m_w | (lit & 32'hFF);
                    m_z = (m_w == 0);
                end
                default: ;
            endcase
        end
        m_pc = m_pc & 32'h7FFF;
        chk();
    endtask

    // main sequence: directed corners, then random traffic around a mid-run reset
    initial begin
        void'($urandom(32'h07B0));
        rst();
        slot(2, 0, 0, 0, 0, 1);
        slot(6, 0, 0, 32'h0, 0, 1);
        slot(6, 0, 0, 32'h75A, 0, 1);
        slot(1, 0, 3, 0, 32'h01, 1);
        slot(1, 1, 32'h7F, 0, 32'h00, 1);
        slot(3, 0, 5, 0, 32'h01, 1);
        slot(6, 0, 0, 32'hFF, 0, 1);
        slot(4, 1, 9, 0, 32'hFF, 1);
        slot(2, 0, 0, 0, 0, 1);
        slot(4, 0, 2, 0, 32'h7F, 1);
        slot(3, 1, 2, 0, 32'h02, 1);
        PAGE_LATCH = 7'h28;
        slot(5, 0, 0, 32'h7FF, 0, 1);
        slot(5, 0, 0, 0, 0, 1);
        PAGE_LATCH = 7'h50;
        slot(5, 0, 0, 32'h123, 0, 1);
        slot(1, 0, 0, 0, 32'h10, 1);
        slot(2, 0, 0, 0, 0, 0);
        $display("directed slots done");
        repeat (2) begin
            for (int i = 0; i < 400; i++) begin
                PAGE_LATCH = 7'($urandom);
                slot($urandom % 7, $urandom % 2, $urandom, $urandom, $urandom,
                    m_sq ? 1 : ($urandom % 4 != 0));
            end
            $display("random pass done");
            rst();
        end
        end_of_test();
    end

    // watchdog well beyond the ~820 slots of the run
    initial begin
        #40000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end
endmodule // test_byte_op_and_branch_execute
